// *** core/pmp_map.svh ***
/*
  Address map, field positions and erased values of the program memory protection block.
  Assumes byte addressing on a 22-bit table pointer.
*/
`ifndef PMP_MAP_SVH
`define PMP_MAP_SVH

`define PMP_BOOT_END 22'h0007FF
`define PMP_BLK0_BASE 22'h000800
`define PMP_REGION_SHIFT 14
`define PMP_USER_END 22'h00FFFF
`define PMP_CFG_CP 22'h300008
`define PMP_CFG_CPH 22'h300009
`define PMP_CFG_WR 22'h30000A
`define PMP_CFG_WRH 22'h30000B
`define PMP_CFG_RD 22'h30000C
`define PMP_CFG_RDH 22'h30000D
`define PMP_DEVID_LO 22'h3FFFFE
`define PMP_DEVID_HI 22'h3FFFFF
`define PMP_BIT_EE_CP 7
`define PMP_BIT_BOOT_CP 6
`define PMP_BIT_EE_WP 7
`define PMP_BIT_BOOT_WP 6
`define PMP_BIT_CFG_WP 5
`define PMP_BIT_BOOT_RD 6
`define PMP_ERASED 8'hFF

`endif

// *** core/pmp_pkg.sv ***
/*
  Types of the program memory protection block.
  Assumes pmp_map.svh is on the include path.
*/
package pmp_pkg;

  // one bit per region: index 0 boot, 1..4 blocks 0..3
  typedef logic [4:0] pmp_region_vec_t;

  typedef struct packed {
    pmp_region_vec_t code_prot;
    pmp_region_vec_t write_prot;
    pmp_region_vec_t read_prot;
    logic eeprom_code_protect;
    logic eeprom_write_protect;
    logic config_write_protect;
  } pmp_cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [21:0] addr;
    logic [7:0] wdata;
  } pmp_req_t;

  typedef enum logic [2:0] {
    PMP_IDLE = 3'b001,
    PMP_READ = 3'b010,
    PMP_WRITE = 3'b100
  } pmp_state_t;

endpackage : pmp_pkg

// *** core/pmp_cfg_store.sv ***
/*
  Protection configuration bits with one-way programming.
  Assumes the caller qualifies every write and erase for its source.
*/
`include "pmp_map.svh"

module pmp_cfg_store (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic prog_in,
  input wire logic [2:0] sel_in,
  input wire logic [7:0] wdata_in,
  input wire logic chip_erase_in,
  input wire logic region_erase_in,
  input wire logic [2:0] erase_region_in,
  output pmp_pkg::pmp_cfg_t cfg_out
);
  import pmp_pkg::*;

  // non-volatile bits: power up erased, untouched by reset
  pmp_cfg_t cfg_r = '1;
  pmp_cfg_t cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    if (prog_in) begin
      case (sel_in)
        3'h0: begin
          cfg_nxt.code_prot[4:1] = cfg_r.code_prot[4:1] & wdata_in[3:0];
        end
        3'h1: begin
          cfg_nxt.eeprom_code_protect = cfg_r.eeprom_code_protect & wdata_in[`PMP_BIT_EE_CP];
          cfg_nxt.code_prot[0] = cfg_r.code_prot[0] & wdata_in[`PMP_BIT_BOOT_CP];
        end
        3'h2: begin
          cfg_nxt.write_prot[4:1] = cfg_r.write_prot[4:1] & wdata_in[3:0];
        end
        3'h3: begin
          cfg_nxt.eeprom_write_protect = cfg_r.eeprom_write_protect & wdata_in[`PMP_BIT_EE_WP];
          cfg_nxt.write_prot[0] = cfg_r.write_prot[0] & wdata_in[`PMP_BIT_BOOT_WP];
          cfg_nxt.config_write_protect = cfg_r.config_write_protect & wdata_in[`PMP_BIT_CFG_WP];
        end
        3'h4: begin
          cfg_nxt.read_prot[4:1] = cfg_r.read_prot[4:1] & wdata_in[3:0];
        end
        3'h5: begin
          cfg_nxt.read_prot[0] = cfg_r.read_prot[0] & wdata_in[`PMP_BIT_BOOT_RD];
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
    if (region_erase_in && erase_region_in <= 3'd4) begin
      cfg_nxt.code_prot[erase_region_in] = 1'b1;
      cfg_nxt.write_prot[erase_region_in] = 1'b1;
      cfg_nxt.read_prot[erase_region_in] = 1'b1;
    end
    if (chip_erase_in) begin
      cfg_nxt = '1;
    end
  end

  // bits are non-volatile: reset leaves them alone
  always_ff @(posedge core_clk_in) begin
    cfg_r <= cfg_nxt;
  end

  assign cfg_out = cfg_r;
endmodule : pmp_cfg_store

// *** core/pmp_protect.sv ***
/*
  Access gate between the CPU table path, the serial programming port and the flash and EEPROM arrays.
  Assumes array accesses finish in the cycle after they are issued and read data return in the same cycle as the read strobe.
*/
`include "pmp_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - user memory split into four 16 Kbyte regions, each separately protected
// - first region split into 2048-byte boot and 14 Kbyte region
// - boot 000000h-0007FFh, next from 000800h, later regions contiguous
// - each region has code, write and cross-read protect bits
// - code protect does not affect CPU table reads or writes
// - code protect blocks programmer reads and writes of the region
// - write protect at zero suppresses table writes into the region
// - cross-read protect zero: reads from inside the region return data
// - cross-read protect zero: reads from outside the region return zeros
// - protection bits only go from one to zero
// - only chip or region erase restores a bit to one
// - erase commands accepted only from the programming port
// - table operations reach any user memory location, subject to protection
// - device identification words are readable by table read
// - configuration words readable and writable by table operations
// - eeprom code protect blocks programmer eeprom reads and writes
// - eeprom write protect blocks programmer eeprom writes
// - CPU eeprom accesses ignore eeprom protection bits
// - config write protect is read-only to user code
module pmp_protect #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter logic [7:0] DEV_ID_LO = 8'hA5,  // arbitrary value
  parameter logic [7:0] DEV_ID_HI = 8'h5A   // arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input pmp_pkg::pmp_req_t cpu_req_in,
  input wire logic [21:0] cpu_pc_in,
  input pmp_pkg::pmp_req_t prg_req_in,
  input wire logic prg_chip_erase_in,
  input wire logic prg_region_erase_in,
  input wire logic [2:0] prg_erase_region_in,
  input wire logic cpu_ee_rd_in,
  input wire logic cpu_ee_wr_in,
  input wire logic prg_ee_rd_in,
  input wire logic prg_ee_wr_in,
  input wire logic [7:0] flash_rdata_in,
  input wire logic [7:0] ee_rdata_in,
  output logic flash_rd_out,
  output logic flash_wr_out,
  output logic [21:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic ee_rd_out,
  output logic ee_wr_out,
  output logic [7:0] table_latch_out,
  output logic table_latch_vld_out,
  output logic [7:0] prg_rdata_out,
  output logic prg_rdata_vld_out,
  output logic prg_blocked_out
);
  import pmp_pkg::*;

  typedef struct packed {
    pmp_state_t st;
    logic from_prg;
    logic use_zero;
    logic use_reg;
    logic [7:0] reg_data;
    logic flash_rd;
    logic flash_wr;
    logic [21:0] flash_addr;
    logic [7:0] flash_wdata;
    logic ee_rd;
    logic ee_wr;
    logic [7:0] latch;
    logic latch_vld;
    logic [7:0] prg_rdata;
    logic prg_vld;
    logic prg_blocked;
  } pmp_state_all_t;

  pmp_state_all_t s_r;
  pmp_state_all_t s_nxt;
  pmp_cfg_t cfg;
  pmp_cfg_t cfg_eff;
  logic cfg_prog;
  logic [2:0] cfg_sel;
  logic [7:0] cfg_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // region decode
  function automatic logic [2:0] region_of(input logic [21:0] a);
    if (a <= `PMP_BOOT_END) begin
      return 3'd0;
    end
    return 3'd1 + {1'b0, a[`PMP_REGION_SHIFT+1:`PMP_REGION_SHIFT]};
  endfunction : region_of

  function automatic logic in_user(input logic [21:0] a);
    return a <= `PMP_USER_END;
  endfunction : in_user

  function automatic logic is_cfg(input logic [21:0] a);
    return a >= `PMP_CFG_CP && a <= `PMP_CFG_RDH;
  endfunction : is_cfg

  function automatic logic is_devid(input logic [21:0] a);
    return a == `PMP_DEVID_LO || a == `PMP_DEVID_HI;
  endfunction : is_devid

  //////////////////////////////////////////////////////////////////////////////
  // programmer and CPU access gates
  function automatic logic prg_allowed(input pmp_cfg_t c, input logic [2:0] rg);
    return c.code_prot[rg];
  endfunction : prg_allowed

  function automatic logic cpu_wr_allowed(input pmp_cfg_t c, input logic [2:0] rg);
    return c.write_prot[rg];
  endfunction : cpu_wr_allowed

  function automatic logic cpu_rd_zero(input pmp_cfg_t c, input logic [2:0] rg, input logic [21:0] pc,
    input logic gone);
    return gone || (!c.read_prot[rg] && region_of(pc) != rg);
  endfunction : cpu_rd_zero

  function automatic logic [1:0] prg_ee_gate(input pmp_cfg_t c, input logic rd, input logic wr);
    logic [1:0] g;
    g[1] = rd && c.eeprom_code_protect;
    g[0] = wr && c.eeprom_code_protect && c.eeprom_write_protect;
    return g;
  endfunction : prg_ee_gate

  function automatic logic is_absent(input logic [2:0] rg);
    return !LARGE_VARIANT && rg == 3'd4;
  endfunction : is_absent

  //////////////////////////////////////////////////////////////////////////////
  // user code never clears the config lock bit
  // masking here lets both paths share the store's one-way logic
  function automatic logic [7:0] user_cfg_wdata(input logic [2:0] sel, input logic [7:0] d);
    logic [7:0] m;
    m = d;
    if (sel == 3'h3) begin
      m[`PMP_BIT_CFG_WP] = 1'b1;
    end
    return m;
  endfunction : user_cfg_wdata

  //////////////////////////////////////////////////////////////////////////////
  // missing region reads as protected-but-absent
  // forcing the bits to zero keeps every path except CPU reads from code in the absent range away from it
  always_comb begin
    cfg_eff = cfg;
    if (!LARGE_VARIANT) begin
      cfg_eff.code_prot[4] = 1'b0;
      cfg_eff.write_prot[4] = 1'b0;
      cfg_eff.read_prot[4] = 1'b0;
    end
  end

  function automatic logic [7:0] cfg_read(input logic [2:0] sel, input pmp_cfg_t c);
    case (sel)
      3'h0: return {4'h0, c.code_prot[4:1]};
      3'h1: return {c.eeprom_code_protect, c.code_prot[0], 6'h00};
      3'h2: return {4'h0, c.write_prot[4:1]};
      3'h3: return {c.eeprom_write_protect, c.write_prot[0], c.config_write_protect, 5'h00};
      3'h4: return {4'h0, c.read_prot[4:1]};
      3'h5: return {1'b0, c.read_prot[0], 6'h00};
      default: return 8'h00;
    endcase
  endfunction : cfg_read

  //////////////////////////////////////////////////////////////////////////////
  // config writes reach the store
  // one writer per cycle: the programmer before user code
  always_comb begin
    cfg_prog = 1'b0;
    cfg_sel = 3'h0;
    cfg_wdata = `PMP_ERASED;
    if (s_r.st == PMP_IDLE) begin
      if (prg_req_in.wr && is_cfg(prg_req_in.addr)) begin
        cfg_prog = 1'b1;
        cfg_sel = 3'(prg_req_in.addr - `PMP_CFG_CP);
        cfg_wdata = prg_req_in.wdata;
      end else if (!prg_req_in.rd && !prg_req_in.wr && cpu_req_in.wr && is_cfg(cpu_req_in.addr)) begin
        cfg_prog = cfg.config_write_protect;
        cfg_sel = 3'(cpu_req_in.addr - `PMP_CFG_CP);
        cfg_wdata = user_cfg_wdata(cfg_sel, cpu_req_in.wdata);
      end
    end
  end

  // erase inputs come only from the programming port
  // erase is not held off by the state machine and may land in a busy cycle
  pmp_cfg_store u_store (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .prog_in(cfg_prog),
    .sel_in(cfg_sel),
    .wdata_in(cfg_wdata),
    .chip_erase_in(prg_chip_erase_in),
    .region_erase_in(prg_region_erase_in),
    .erase_region_in(prg_erase_region_in),
    .cfg_out(cfg)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pmp_req_t rq;
    logic [2:0] rg;
    logic absent;
    s_nxt = s_r;
    rq = cpu_req_in;
    rg = 3'd0;
    absent = 1'b0;
    s_nxt.flash_rd = 1'b0;
    s_nxt.flash_wr = 1'b0;
    s_nxt.ee_rd = 1'b0;
    s_nxt.ee_wr = 1'b0;
    s_nxt.latch_vld = 1'b0;
    s_nxt.prg_vld = 1'b0;
    s_nxt.prg_blocked = 1'b0;
    // a request that loses arbitration or arrives while busy is dropped
    case (s_r.st)
      PMP_IDLE: begin
        s_nxt.from_prg = prg_req_in.rd || prg_req_in.wr;
        rq = s_nxt.from_prg ? prg_req_in : cpu_req_in;
        rg = region_of(rq.addr);
        absent = is_absent(rg);
        s_nxt.use_zero = 1'b0;
        s_nxt.use_reg = 1'b0;
        s_nxt.reg_data = 8'h00;
        s_nxt.flash_addr = rq.addr;
        s_nxt.flash_wdata = rq.wdata;
        if (rq.rd) begin
          s_nxt.st = PMP_READ;
          if (is_cfg(rq.addr)) begin
            s_nxt.use_reg = 1'b1;
            s_nxt.reg_data = cfg_read(3'(rq.addr - `PMP_CFG_CP), cfg_eff);
          end else if (is_devid(rq.addr)) begin
            s_nxt.use_reg = 1'b1;
            s_nxt.reg_data = rq.addr[0] ? DEV_ID_HI : DEV_ID_LO;
          end else if (in_user(rq.addr)) begin
            if (s_nxt.from_prg) begin
              s_nxt.use_zero = !prg_allowed(cfg_eff, rg) || absent;
              s_nxt.prg_blocked = !prg_allowed(cfg_eff, rg);
            end else begin
              s_nxt.use_zero = cpu_rd_zero(cfg_eff, rg, cpu_pc_in, absent);
            end
            s_nxt.flash_rd = !s_nxt.use_zero;
          end else begin
            s_nxt.flash_rd = 1'b1;
          end
        end else if (rq.wr) begin
          s_nxt.st = PMP_WRITE;
          if (in_user(rq.addr) && !absent) begin
            if (s_nxt.from_prg) begin
              s_nxt.flash_wr = prg_allowed(cfg_eff, rg);
              s_nxt.prg_blocked = !prg_allowed(cfg_eff, rg);
            end else begin
              s_nxt.flash_wr = cpu_wr_allowed(cfg_eff, rg);
            end
          end else if (!in_user(rq.addr) && !is_cfg(rq.addr)) begin
            s_nxt.flash_wr = 1'b1;
          end
        end else if (prg_ee_rd_in || prg_ee_wr_in) begin
          {s_nxt.ee_rd, s_nxt.ee_wr} = prg_ee_gate(cfg_eff, prg_ee_rd_in, prg_ee_wr_in);
          s_nxt.prg_blocked = !(prg_ee_rd_in ? s_nxt.ee_rd : s_nxt.ee_wr);
        end else begin
          s_nxt.ee_rd = cpu_ee_rd_in;
          s_nxt.ee_wr = cpu_ee_wr_in;
        end
      end
      PMP_READ: begin
        // the array answers in this cycle
        s_nxt.st = PMP_IDLE;
        if (s_r.use_reg) begin
          s_nxt.latch = s_r.reg_data;
        end else begin
          s_nxt.latch = s_r.use_zero ? 8'h00 : flash_rdata_in;
        end
        if (s_r.from_prg) begin
          s_nxt.prg_rdata = s_nxt.latch;
          s_nxt.prg_vld = 1'b1;
          s_nxt.latch = s_r.latch;
        end else begin
          s_nxt.latch_vld = 1'b1;
        end
      end
      PMP_WRITE: begin
        // nothing comes back; the cycle only spaces requests
        s_nxt.st = PMP_IDLE;
      end
      default: begin
        s_nxt.st = PMP_IDLE;
      end
    endcase
  end

  // protection bits live in the store and keep their value through reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.st <= PMP_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign flash_rd_out = s_r.flash_rd;
  assign flash_wr_out = s_r.flash_wr;
  assign flash_addr_out = s_r.flash_addr;
  assign flash_wdata_out = s_r.flash_wdata;
  assign ee_rd_out = s_r.ee_rd;
  assign ee_wr_out = s_r.ee_wr;
  assign table_latch_out = s_r.latch;
  assign table_latch_vld_out = s_r.latch_vld;
  assign prg_rdata_out = s_r.prg_rdata;
  assign prg_rdata_vld_out = s_r.prg_vld;
  assign prg_blocked_out = s_r.prg_blocked;
endmodule : pmp_protect

// *** bench/pmp_flash_model.sv ***
/*
  Flash array stand-in for the protection gate.
  Assumes the gate holds the address through the read cycle.
*/
module pmp_flash_model (
  input wire logic rd_in,
  input wire logic [21:0] addr_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus shows the inverse, so stale data cannot pass
  assign rdata_out = rd_in ? (addr_in[7:0] ^ 8'h3C) : ~(addr_in[7:0] ^ 8'h3C);
endmodule : pmp_flash_model

// *** bench/pmp_protect_monitor.sv ***
/*
  Port checker of the protection gate.
  Assumes single clock, sync reset, bound to pmp_protect.
*/
module pmp_protect_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input pmp_pkg::pmp_req_t cpu_req_in,
  input pmp_pkg::pmp_req_t prg_req_in,
  input wire logic cpu_ee_rd_in,
  input wire logic cpu_ee_wr_in,
  input wire logic prg_ee_rd_in,
  input wire logic prg_ee_wr_in,
  input wire logic flash_rd_out,
  input wire logic flash_wr_out,
  input wire logic [21:0] flash_addr_out,
  input wire logic ee_rd_out,
  input wire logic ee_wr_out,
  input wire logic [7:0] table_latch_out,
  input wire logic table_latch_vld_out,
  input wire logic prg_rdata_vld_out,
  input wire logic prg_blocked_out
);
  import pmp_pkg::*;
  logic q;
  logic nohi;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // blocked cases are left out: their busy cycle is not visible here
  assign q = !(flash_rd_out | flash_wr_out | prg_blocked_out);
  assign nohi = !(prg_req_in.rd | prg_req_in.wr | cpu_req_in.rd | cpu_req_in.wr | prg_ee_rd_in | prg_ee_wr_in);
  //////////////////////////////////////////
  a_cpu_read_issue: assert property (
    q && cpu_req_in.rd && !prg_req_in.rd && !prg_req_in.wr && cpu_req_in.addr <= 22'h00FFFF
    |=> flash_addr_out == $past(cpu_req_in.addr)
    ##1 table_latch_vld_out && ($past(flash_rd_out) || table_latch_out == 8'h00))
    else $error("cpu table read not issued");
  a_cpu_ee_pass: assert property (q && nohi && cpu_ee_rd_in |=> ee_rd_out)
    else $error("cpu eeprom read dropped");
  a_rd_pulse: assert property (flash_rd_out |=> !flash_rd_out)
    else $error("flash read longer than one cycle");
  a_rd_wr_excl: assert property (!(flash_rd_out && flash_wr_out))
    else $error("flash read and write together");
  a_ee_wr_cause: assert property (ee_wr_out |-> $past(cpu_ee_wr_in || prg_ee_wr_in))
    else $error("eeprom write without request");
  a_rdata_cause: assert property (prg_rdata_vld_out |-> $past(prg_req_in.rd || prg_ee_rd_in, 2))
    else $error("programmer data without read");
  a_block_cause: assert property (
    prg_blocked_out |-> $past(prg_req_in.rd | prg_req_in.wr | prg_ee_rd_in | prg_ee_wr_in))
    else $error("refusal without programmer request");
  a_latch_hold: assert property (!table_latch_vld_out |-> $stable(table_latch_out))
    else $error("table latch changed without read");
  cover property (table_latch_vld_out && table_latch_out == 8'h00);
  cover property (prg_blocked_out);
  cover property (flash_wr_out);
endmodule : pmp_protect_monitor

bind pmp_protect pmp_protect_monitor u_mon (.core_clk_in, .rst_in, .cpu_req_in, .prg_req_in,
  .cpu_ee_rd_in, .cpu_ee_wr_in, .prg_ee_rd_in, .prg_ee_wr_in, .flash_rd_out, .flash_wr_out,
  .flash_addr_out, .ee_rd_out, .ee_wr_out, .table_latch_out, .table_latch_vld_out,
  .prg_rdata_vld_out, .prg_blocked_out);

// *** bench/program_memory_code_protection_tb_top.sv ***
/*
  Self-checking bench of the protection gate.
  Assumes the flash model answers reads; both memory variants run side by side.
*/
module program_memory_code_protection_tb_top import pmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_LO = 8'h96;  // arbitrary value
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  pmp_req_t cpu_req_in = '0;
  pmp_req_t prg_req_in = '0;
  logic [21:0] cpu_pc_in = '0;
  logic prg_chip_erase_in = 1'h0;
  logic prg_region_erase_in = 1'h0;
  logic [2:0] prg_erase_region_in = 3'h0;
  logic cpu_ee_rd_in = 1'h0;
  logic cpu_ee_wr_in = 1'h0;
  logic prg_ee_rd_in = 1'h0;
  logic prg_ee_wr_in = 1'h0;
  logic [7:0] flash_rdata_in;
  logic [7:0] ee_rdata_in = 8'h00;
  logic flash_rd_out, flash_wr_out, ee_rd_out, ee_wr_out;
  logic table_latch_vld_out, prg_rdata_vld_out, prg_blocked_out;
  logic [21:0] flash_addr_out;
  logic [7:0] flash_wdata_out, table_latch_out, prg_rdata_out;
  logic [7:0] sm_latch;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] erased [6] = '{8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

  pmp_protect #(.LARGE_VARIANT(1'h1), .DEV_ID_LO(ID_LO), .DEV_ID_HI(8'h69)) dut (.core_clk_in,
    .rst_in, .cpu_req_in, .cpu_pc_in, .prg_req_in, .prg_chip_erase_in, .prg_region_erase_in,
    .prg_erase_region_in, .cpu_ee_rd_in, .cpu_ee_wr_in, .prg_ee_rd_in, .prg_ee_wr_in,
    .flash_rdata_in, .ee_rdata_in, .flash_rd_out, .flash_wr_out, .flash_addr_out,
    .flash_wdata_out, .ee_rd_out, .ee_wr_out, .table_latch_out, .table_latch_vld_out,
    .prg_rdata_out, .prg_rdata_vld_out, .prg_blocked_out);
  pmp_flash_model u_flash (.rd_in(flash_rd_out), .addr_in(flash_addr_out), .rdata_out(flash_rdata_in));
  // small variant shares every input; only its table latch is watched
  pmp_protect #(.LARGE_VARIANT(1'h0), .DEV_ID_LO(ID_LO), .DEV_ID_HI(8'h69)) dut_small (.core_clk_in,
    .rst_in, .cpu_req_in, .cpu_pc_in, .prg_req_in, .prg_chip_erase_in, .prg_region_erase_in,
    .prg_erase_region_in, .cpu_ee_rd_in, .cpu_ee_wr_in, .prg_ee_rd_in, .prg_ee_wr_in,
    .flash_rdata_in, .ee_rdata_in, .flash_rd_out(), .flash_wr_out(), .flash_addr_out(),
    .flash_wdata_out(), .ee_rd_out(), .ee_wr_out(), .table_latch_out(sm_latch), .table_latch_vld_out(),
    .prg_rdata_out(), .prg_rdata_vld_out(), .prg_blocked_out());

  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  //////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction : pat
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cpu_rd(input logic [21:0] a, input logic [21:0] p, input logic [7:0] exp);
    @(negedge core_clk_in);
    cpu_req_in = '{1'h1, 1'h0, a, 8'h00};
    cpu_pc_in = p;
    @(negedge core_clk_in);
    cpu_req_in.rd = 1'h0;
    @(negedge core_clk_in);
    chk("latch valid", 8'h01, {7'h00, table_latch_vld_out});
    chk("table latch", exp, table_latch_out);
  endtask : cpu_rd
  task automatic cpu_wr(input logic [21:0] a, input logic [7:0] d, input logic [7:0] w);
    @(negedge core_clk_in);
    cpu_req_in = '{1'h0, 1'h1, a, d};
    @(negedge core_clk_in);
    cpu_req_in.wr = 1'h0;
    chk("flash write", w, {7'h00, flash_wr_out});
    chk("write data", d, flash_wdata_out);
  endtask : cpu_wr
  task automatic prg(input logic wr, input logic [21:0] a, input logic [7:0] d, input logic [7:0] blk);
    @(negedge core_clk_in);
    prg_req_in = '{~wr, wr, a, d};
    @(negedge core_clk_in);
    prg_req_in = '0;
    chk("prog refused", blk, {7'h00, prg_blocked_out});
    @(negedge core_clk_in);
    if (!wr) chk("prog valid", 8'h01, {7'h00, prg_rdata_vld_out});
    if (!wr) chk("prog data", blk[0] ? 8'h00 : pat(a), prg_rdata_out);
  endtask : prg
  task automatic ee(input logic [3:0] req, input logic [7:0] exp);
    @(negedge core_clk_in);
    {cpu_ee_rd_in, cpu_ee_wr_in, prg_ee_rd_in, prg_ee_wr_in} = req;
    @(negedge core_clk_in);
    {cpu_ee_rd_in, cpu_ee_wr_in, prg_ee_rd_in, prg_ee_wr_in} = 4'h0;
    chk("eeprom strobes", exp, {5'h00, ee_rd_out, ee_wr_out, prg_blocked_out});
  endtask : ee
  task automatic erase(input logic chip, input logic [2:0] r);
    @(negedge core_clk_in);
    prg_chip_erase_in = chip;
    prg_region_erase_in = ~chip;
    prg_erase_region_in = r;
    @(negedge core_clk_in);
    prg_chip_erase_in = 1'h0;
    prg_region_erase_in = 1'h0;
  endtask : erase
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////
  initial begin
    repeat (3) @(negedge core_clk_in);
    rst_in = 1'h0;
    for (int i = 0; i < 6; i++) begin
      cpu_rd({19'h60001, i[2:0]}, 22'h0, erased[i]);
    end
    cpu_rd(22'h3FFFFE, 22'h0, ID_LO);
    $display("test erased config done");
    cpu_rd(22'h000FFF, 22'h004FFE, pat(22'h000FFF));
    cpu_wr(22'h30000C, 8'hFE, 8'h00);
    cpu_rd(22'h000FFF, 22'h004FFE, 8'h00);
    cpu_rd(22'h000FFF, 22'h000900, pat(22'h000FFF));
    cpu_wr(22'h30000D, 8'h00, 8'h00);
    cpu_rd(22'h0007FF, 22'h000800, 8'h00);
    cpu_rd(22'h0007FF, 22'h0007FE, pat(22'h0007FF));
    cpu_wr(22'h30000C, 8'hFF, 8'h00);
    cpu_rd(22'h30000C, 22'h0, 8'h0E);
    $display("test cross read done");
    cpu_wr(22'h004000, 8'h55, 8'h01);
    cpu_wr(22'h30000A, 8'hFD, 8'h00);
    cpu_wr(22'h004000, 8'h55, 8'h00);
    cpu_wr(22'h003FFF, 8'h55, 8'h01);
    cpu_wr(22'h300008, 8'hFE, 8'h00);
    cpu_rd(22'h001000, 22'h001000, pat(22'h001000));
    cpu_wr(22'h001000, 8'h33, 8'h01);
    $display("test write protect done");
    prg(1'h0, 22'h001000, 8'h00, 8'h01);
    prg(1'h1, 22'h001000, 8'hAA, 8'h01);
    prg(1'h0, 22'h004000, 8'h00, 8'h00);
    erase(1'h0, 3'h1);
    cpu_rd(22'h300008, 22'h0, 8'h0F);
    prg(1'h0, 22'h001000, 8'h00, 8'h00);
    $display("test programmer done");
    ee(4'h1, 8'h02);
    prg(1'h1, 22'h30000B, 8'h7F, 8'h00);
    ee(4'h1, 8'h01);
    ee(4'h2, 8'h04);
    ee(4'h4, 8'h02);
    prg(1'h1, 22'h300009, 8'h7F, 8'h00);
    ee(4'h2, 8'h01);
    ee(4'h8, 8'h04);
    $display("test eeprom done");
    cpu_wr(22'h30000B, 8'hDF, 8'h00);
    cpu_rd(22'h30000B, 22'h0, 8'h60);
    prg(1'h1, 22'h30000B, 8'hDF, 8'h00);
    cpu_rd(22'h30000B, 22'h0, 8'h40);
    cpu_wr(22'h300009, 8'h00, 8'h00);
    cpu_rd(22'h300009, 22'h0, 8'h40);
    erase(1'h1, 3'h0);
    cpu_rd(22'h30000B, 22'h0, 8'hE0);
    $display("test config protect done");
    cpu_rd(22'h00C000, 22'h00C000, pat(22'h00C000));
    chk("small top region", 8'h00, sm_latch);
    cpu_rd(22'h30000C, 22'h0, 8'h0F);
    chk("small config", 8'h07, sm_latch);
    $display("test small variant done");
    final_report();
  end
endmodule : program_memory_code_protection_tb_top
